/* File: core/mcs_core.v */
// Eight-channel asynchronous serial core with AHB-Lite register slave
//
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "mcs_regs.vh"

// Function
// - Three independent request machines, each queueing more than one request.
// - Machine drives request line, watches acknowledges, reports completed service.
// - Acknowledge returns vector and sets channel context; end of service restores it.
// - Each level queue is two deep; with fair share off, next request posts with no gap.
// - In-band mode stops and restarts transmitter on received flow characters.
// - Host command inserts a flow-control character into the transmit stream.
// - Out-of-band mode asserts RTS and holds transmission until CTS grants.
// - Receive flow control drives DTR from FIFO fill versus programmed threshold.
// - DSR can gate the receiver on and off.
// - Requests granted fair-share within device and across daisy-chained devices.
// - Channels configured independently; separate loaded rx and tx divisors.
// - Detect received break; embedded commands send break or insert delay.
// - Special character match raises a distinct exception service request.
// - Parity checked automatically; host can force parity errors.
// - Character length and stop length programmable per channel.
// - Modem pins host readable and writable; programmed changes raise requests.
// - Receive tick samples input pin and reports bit to character logic.
// - Transmit tick drives next bit and requests the following one.
// - 16-bit baud dividers per direction, clocked by system clock over 16.
// - 8-bit per-channel timer times out partly filled receive FIFO.
// - Second per-channel timer measures embedded transmit delays.
// - Channel service shares one priority; served channel waits for others.
// - Each channel has eight-entry transmit, receive and status FIFOs.
// - Levels are receive, transmit and modem; all may assert together.
// - Character mover checks receive before transmit.
module mcs_core (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire [7:0]  rxd,
  output wire [7:0]  txd,
  input  wire [7:0]  cts,
  input  wire [7:0]  dsr,
  input  wire [7:0]  cd,
  output wire [7:0]  rts,
  output wire [7:0]  dtr,
  input  wire [2:0]  srq_n_in,
  output wire [2:0]  srq_n_out,
  output wire [2:0]  srq_n_oe_n
);

  // ----------------------------------------------------------------
  // Fair-share pick: lowest pending not yet served, else lowest pending
  // ----------------------------------------------------------------
  function [3:0] mcs_pick;
    input [7:0] p;
    input [7:0] s;
    integer i;
    reg [7:0] m;
    begin
      mcs_pick = 4'h0;
      m = p & ~s;
      if (m == 8'h00)
        m = p;
      for (i = 7; i >= 0; i = i - 1)
        if (m[i])
          mcs_pick = {1'b1, i[2:0]};
    end
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave: one wait state, action on the first data cycle
  // ----------------------------------------------------------------
  reg        dp_q;
  reg        done_q;
  reg        a_we_q;
  reg        a_hi_q;
  reg [8:0]  a_addr_q;
  reg        fair_en_q;
  wire       act    = dp_q & ~done_q;
  wire [2:0] a_off  = a_addr_q[4:2];
  wire [2:0] a_ch   = a_addr_q[7:5];
  wire       a_glb  = a_addr_q[`MCS_GLB_BIT] & ~a_hi_q;
  wire       a_chs  = ~a_addr_q[`MCS_GLB_BIT] & ~a_hi_q;
  wire [255:0] ch_rd;
  wire [7:0]   rxc;
  wire [7:0]   txc;
  wire [7:0]   mdc;
  wire [7:0]   exc;
  wire [23:0]  ack_dat;
  wire [8:0]   ctx_dat;
  wire [2:0]   eos_l;
  reg  [31:0]  rd_mux;

  assign hreadyout = ~dp_q | done_q;
  assign hresp     = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_q     <= 1'b0;
      done_q   <= 1'b0;
      a_we_q   <= 1'b0;
      a_hi_q   <= 1'b0;
      a_addr_q <= 9'h000;
      hrdata   <= 32'h0000_0000;
    end else begin
      if (hready && hsel && htrans[1]) begin
        dp_q     <= 1'b1;
        done_q   <= 1'b0;
        a_we_q   <= hwrite;
        a_hi_q   <= (haddr[31:9] != 23'h000000);
        a_addr_q <= haddr[8:0];
      end else if (hready) begin
        dp_q <= 1'b0;
      end else if (act) begin
        done_q <= 1'b1;
      end
      if (act && !a_we_q)
        hrdata <= rd_mux;
    end
  end

  always @* begin
    rd_mux = 32'h0000_0000;
    if (a_chs)
      rd_mux = ch_rd[a_ch*32 +: 32];
    else if (a_glb) begin
      case (a_off)
        `MCS_OFF_ACK_RX:  rd_mux = {24'h000000, ack_dat[7:0]};
        `MCS_OFF_ACK_TX:  rd_mux = {24'h000000, ack_dat[15:8]};
        `MCS_OFF_ACK_MDM: rd_mux = {24'h000000, ack_dat[23:16]};
        `MCS_OFF_CTX:     rd_mux = {23'h000000, ctx_dat};
        `MCS_OFF_GCFG:    rd_mux = {31'h00000000, fair_en_q};
        default:          rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      fair_en_q <= 1'b0;
    else if (act && a_we_q && a_glb && a_off == `MCS_OFF_GCFG)
      fair_en_q <= hwdata[0];
  end

  // ----------------------------------------------------------------
  // Master prescaler tick and fair character mover
  // ----------------------------------------------------------------
  reg  [3:0] pre_q;
  reg  [7:0] mv_srv_q;
  wire       mtick = (pre_q == `MCS_PRESCALE_MAX);
  wire [7:0] mv_req;
  wire [3:0] mv_pk = mcs_pick(mv_req, mv_srv_q);
  wire [7:0] mv_oh = 8'h01 << mv_pk[2:0];
  wire [7:0] gnt   = mv_pk[3] ? mv_oh : 8'h00;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q    <= 4'h0;
      mv_srv_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 4'h1;
      if (mv_pk[3])
        mv_srv_q <= ((mv_req & ~mv_srv_q) == 8'h00) ? mv_oh : (mv_srv_q | mv_oh);
    end
  end

  // ----------------------------------------------------------------
  // Service request machines, one per level
  // ----------------------------------------------------------------
  reg [2:0] lsync1_q;
  reg [2:0] lsync2_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lsync1_q <= 3'h7;
      lsync2_q <= 3'h7;
    end else begin
      lsync1_q <= srq_n_in;
      lsync2_q <= lsync1_q;
    end
  end
  assign srq_n_out = 3'h0;

  genvar l;
  generate
    for (l = 0; l < 3; l = l + 1) begin : g_lvl
      localparam [1:0] LI = l;
      reg  [4:0] q0_q;
      reg  [4:0] q1_q;
      reg  [1:0] qn_q;
      reg  [7:0] qm_q;
      reg  [7:0] srv_q;
      reg        svc_q;
      reg        hold_q;
      reg        oe_n_q;
      wire [7:0] cnd  = ((l == 0) ? rxc : (l == 1) ? txc : mdc) & ~qm_q;
      wire [3:0] pk   = mcs_pick(cnd, srv_q);
      wire [7:0] oh   = 8'h01 << pk[2:0];
      wire       ack  = act & ~a_we_q & a_glb & (a_off == {1'b0, LI}) & ~oe_n_q & ~svc_q;
      wire       eos  = act & a_we_q & a_glb & (a_off == `MCS_OFF_EOSR) &
                        (hwdata[1:0] == LI) & svc_q;
      wire [1:0] nleft = qn_q - {1'b0, eos};
      wire       push = pk[3] & (nleft != 2'h2);
      wire [1:0] vec  = (l == 0) ? (exc[pk[2:0]] ? `MCS_VEC_EXC : `MCS_VEC_GOOD) :
                        (l == 1) ? `MCS_VEC_TX : `MCS_VEC_MDM;
      assign ack_dat[l*8 +: 8] = ack ? {3'h4, q0_q} : 8'h00;
      assign ctx_dat[l*3 +: 3] = svc_q ? q0_q[2:0] : 3'h0;
      assign eos_l[l]          = eos;
      assign srq_n_oe_n[l]     = oe_n_q;
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          q0_q   <= 5'h00;
          q1_q   <= 5'h00;
          qn_q   <= 2'h0;
          qm_q   <= 8'h00;
          srv_q  <= 8'h00;
          svc_q  <= 1'b0;
          hold_q <= 1'b0;
          oe_n_q <= 1'b1;
        end else begin
          if (ack)
            svc_q <= 1'b1;
          if (eos) begin
            svc_q  <= 1'b0;
            hold_q <= fair_en_q;
            q0_q   <= q1_q;
            qm_q   <= qm_q & ~(8'h01 << q0_q[2:0]);
          end else if (hold_q && lsync2_q[l]) begin
            hold_q <= 1'b0;
          end
          if (push) begin
            if (nleft == 2'h0)
              q0_q <= {vec, pk[2:0]};
            else
              q1_q <= {vec, pk[2:0]};
            qm_q  <= (eos ? (qm_q & ~(8'h01 << q0_q[2:0])) : qm_q) | oh;
            srv_q <= ((cnd & ~srv_q) == 8'h00) ? oh : (srv_q | oh);
          end
          qn_q   <= nleft + {1'b0, push};
          oe_n_q <= ~((qn_q != 2'h0) & ~svc_q & ~ack & ~hold_q);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Serial channels
  // ----------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < 8; c = c + 1) begin : g_ch
      localparam [2:0] CI = c;
      reg [12:0] cfg_q;
      reg [31:0] baud_q;
      reg [31:0] spec_q;
      reg [7:0]  tmr_rl_q;
      reg [4:0]  mdm_q;
      reg        spx_q, spf_q, stop_q, ovr_q, tmo_q, chg_q, brk_q;
      reg [11:0] rxm [0:7];
      reg [8:0]  txm [0:7];
      reg [2:0]  rwp_q, rrp_q, twp_q, trp_q;
      reg [3:0]  rn_q, tn_q;
      reg [11:0] rxh_q;
      reg        rxh_f_q;
      reg [9:0]  txh_q;
      reg        txh_f_q;
      reg [15:0] tdiv_q, rdiv_q;
      reg [11:0] tsh_q;
      reg [3:0]  tcnt_q, ridx_q;
      reg [7:0]  dly_q, tmr_q, rsh_q;
      reg        txd_q, rbusy_q, rpar_q, rz_q, dtr_q, rts_q;
      reg [3:0]  s1_q, s2_q, s3_q;
      wire       wr    = act & a_we_q & a_chs & (a_ch == CI);
      wire       rd    = act & ~a_we_q & a_chs & (a_ch == CI);
      wire [1:0] len   = cfg_q[1:0];
      wire [3:0] dl    = 4'h5 + {2'b00, len};
      wire       paren = cfg_q[`MCS_CFG_PAREN];
      wire       odd   = cfg_q[`MCS_CFG_PARODD];
      wire [7:0] td    = txh_q[7:0] & (8'hFF >> (2'h3 - len));
      wire       tpb   = paren ? ((^td) ^ odd) : 1'b1;
      wire [11:0] tfr  = {3'h0, td, 1'b0} | ({11'h7FF, tpb} << (dl + 4'h1));
      wire [3:0] tnb   = dl + 4'h2 + {3'h0, paren} + {3'h0, cfg_q[`MCS_CFG_STOP2]};
      wire       ttick = mtick & (tdiv_q == 16'h0000);
      wire       rtick = mtick & (rdiv_q == 16'h0000);
      wire [7:0] rc    = rsh_q >> (2'h3 - len);
      wire       perr  = (paren & ((^rc) ^ odd ^ rpar_q)) | cfg_q[`MCS_CFG_FORCEPE];
      wire       rx_on = cfg_q[`MCS_CFG_RXEN] & (~cfg_q[`MCS_CFG_DSRGATE] | s2_q[1]);
      wire       cts_ok = ~cfg_q[`MCS_CFG_CTSFC] | s2_q[0];
      wire       mv_rx = gnt[c] & rxh_f_q;
      wire       rpush = mv_rx & (rn_q != 4'h8);
      wire       rpop  = rd & (a_off == `MCS_OFF_DATA) & (rn_q != 4'h0);
      wire       mv_sp = gnt[c] & ~rxh_f_q & ~txh_f_q & (spx_q | spf_q);
      wire       tpop  = gnt[c] & ~rxh_f_q & ~txh_f_q & ~spx_q & ~spf_q & (tn_q != 4'h0);
      wire       tpush = wr & (a_off == `MCS_OFF_DATA) & (tn_q != 4'h8);
      wire       can_tx = txh_f_q & (txh_q[9] | (~stop_q & cts_ok & cfg_q[`MCS_CFG_TXEN]));
      wire       rdone = rbusy_q & rtick & (ridx_q > dl) & ~(paren & (ridx_q == dl + 4'h1));
      wire [7:0] thr   = {4'h0, spec_q[27:24]};
      assign mv_req[c] = rxh_f_q | (~txh_f_q & (spx_q | spf_q | (tn_q != 4'h0)));
      assign exc[c] = (rn_q != 4'h0) & (rxm[rrp_q][11:8] != 4'h0);
      assign rxc[c] = ((thr != 8'h00) & ({4'h0, rn_q} >= thr)) | tmo_q | exc[c];
      assign txc[c] = cfg_q[`MCS_CFG_TXIE] & (tn_q == 4'h0);
      assign mdc[c] = chg_q;
      assign txd[c] = txd_q;
      assign dtr[c] = dtr_q;
      assign rts[c] = rts_q;
      assign ch_rd[c*32 +: 32] =
        (a_off == `MCS_OFF_CFG)  ? {19'h0, cfg_q} :
        (a_off == `MCS_OFF_BAUD) ? baud_q :
        (a_off == `MCS_OFF_DATA) ? ((rn_q != 4'h0) ? {20'h0, rxm[rrp_q]} : 32'h0) :
        (a_off == `MCS_OFF_SPEC) ? spec_q :
        (a_off == `MCS_OFF_CMD)  ? {30'h0, spf_q, spx_q} :
        (a_off == `MCS_OFF_MDM)  ? {22'h0, chg_q, s2_q[2:0], 1'b0, mdm_q} :
        (a_off == `MCS_OFF_STAT) ? {19'h0, rbusy_q, tmo_q, ovr_q, brk_q, stop_q, tn_q, rn_q} :
        {24'h0, tmr_rl_q};
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cfg_q <= `MCS_CFG_RST;  baud_q <= `MCS_BAUD_RST;  spec_q <= `MCS_SPEC_RST;
          tmr_rl_q <= `MCS_TMR_RST;  mdm_q <= 5'h00;
          spx_q <= 1'b0;  spf_q <= 1'b0;  stop_q <= 1'b0;  ovr_q <= 1'b0;
          tmo_q <= 1'b0;  chg_q <= 1'b0;  brk_q <= 1'b0;
          rwp_q <= 3'h0;  rrp_q <= 3'h0;  twp_q <= 3'h0;  trp_q <= 3'h0;
          rn_q <= 4'h0;  tn_q <= 4'h0;  rxh_q <= 12'h000;  rxh_f_q <= 1'b0;
          txh_q <= 10'h000;  txh_f_q <= 1'b0;  tdiv_q <= 16'h0000;  rdiv_q <= 16'h0000;
          tsh_q <= 12'hFFF;  tcnt_q <= 4'h0;  ridx_q <= 4'h0;  dly_q <= 8'h00;
          tmr_q <= 8'h00;  rsh_q <= 8'h00;  txd_q <= 1'b1;  rbusy_q <= 1'b0;
          rpar_q <= 1'b0;  rz_q <= 1'b0;  dtr_q <= 1'b0;  rts_q <= 1'b0;
          s1_q <= 4'hF;  s2_q <= 4'hF;  s3_q <= 4'hF;
        end else begin
          s1_q <= {rxd[c], cd[c], dsr[c], cts[c]};
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (wr) begin
            case (a_off)
              `MCS_OFF_CFG:  cfg_q <= hwdata[12:0];
              `MCS_OFF_BAUD: baud_q <= hwdata;
              `MCS_OFF_SPEC: spec_q <= hwdata;
              `MCS_OFF_MDM:  mdm_q <= hwdata[4:0];
              `MCS_OFF_STAT: ovr_q <= 1'b0;
              `MCS_OFF_TMR:  tmr_rl_q <= hwdata[7:0];
              default:       ;
            endcase
          end
          // Divider and receive-timeout timer
          tdiv_q <= ttick ? baud_q[15:0] : (mtick ? tdiv_q - 16'h0001 : tdiv_q);
          if (rpush | rpop) begin
            tmr_q <= tmr_rl_q;
            tmo_q <= 1'b0;
          end else if (mtick && rn_q != 4'h0 && tmr_q != 8'h00) begin
            tmr_q <= tmr_q - 8'h01;
            if (tmr_q == 8'h01)
              tmo_q <= 1'b1;
          end
          // FIFOs and mover
          if (rpush) begin
            rxm[rwp_q] <= rxh_q;
            rwp_q <= rwp_q + 3'h1;
          end
          if (rpop)
            rrp_q <= rrp_q + 3'h1;
          rn_q <= rn_q + {3'h0, rpush} - {3'h0, rpop};
          if (tpush) begin
            txm[twp_q] <= hwdata[8:0];
            twp_q <= twp_q + 3'h1;
          end
          if (tpop) begin
            txh_q <= {1'b0, txm[trp_q]};
            txh_f_q <= 1'b1;
            trp_q <= trp_q + 3'h1;
          end
          tn_q <= tn_q + {3'h0, tpush} - {3'h0, tpop};
          if (mv_rx)
            rxh_f_q <= 1'b0;
          if (mv_rx && !rpush)
            ovr_q <= 1'b1;
          if (mv_sp) begin
            txh_q <= {2'b10, spx_q ? spec_q[7:0] : spec_q[15:8]};
            txh_f_q <= 1'b1;
            if (spx_q)
              spx_q <= 1'b0;
            else
              spf_q <= 1'b0;
          end
          if (wr && a_off == `MCS_OFF_CMD) begin
            if (hwdata[0])
              spx_q <= 1'b1;
            if (hwdata[1])
              spf_q <= 1'b1;
          end
          // Transmit bit engine
          if (ttick) begin
            if (dly_q != 8'h00) begin
              dly_q <= dly_q - 8'h01;
            end else if (tcnt_q != 4'h0) begin
              txd_q <= tsh_q[0];
              tsh_q <= {1'b1, tsh_q[11:1]};
              tcnt_q <= tcnt_q - 4'h1;
            end else if (txh_f_q && txh_q[8]) begin
              txh_f_q <= 1'b0;
              if (txh_q[7:6] == `MCS_TXC_BRK_ON)
                brk_q <= 1'b1;
              else if (txh_q[7:6] == `MCS_TXC_BRK_OFF)
                brk_q <= 1'b0;
              else if (txh_q[7:6] == `MCS_TXC_DELAY)
                dly_q <= {2'b00, txh_q[5:0]};
              txd_q <= ~(brk_q | (txh_q[7:6] == `MCS_TXC_BRK_ON));
            end else if (can_tx && !brk_q) begin
              txd_q <= 1'b0;
              tsh_q <= {1'b1, tfr[11:1]};
              tcnt_q <= tnb - 4'h1;
              txh_f_q <= 1'b0;
            end else begin
              txd_q <= ~brk_q;
            end
          end
          // Receive bit engine
          if (!rbusy_q) begin
            if (rx_on && s3_q[3] && !s2_q[3]) begin
              rbusy_q <= 1'b1;
              rdiv_q <= {1'b0, baud_q[31:17]};
              ridx_q <= 4'h0;
              rz_q <= 1'b1;
            end
          end else if (mtick) begin
            rdiv_q <= rtick ? baud_q[31:16] : rdiv_q - 16'h0001;
            if (rtick) begin
              ridx_q <= ridx_q + 4'h1;
              if (ridx_q == 4'h0) begin
                if (s2_q[3])
                  rbusy_q <= 1'b0;
              end else if (ridx_q <= dl) begin
                rsh_q <= {s2_q[3], rsh_q[7:1]};
                rz_q <= rz_q & ~s2_q[3];
              end else if (paren && ridx_q == dl + 4'h1) begin
                rpar_q <= s2_q[3];
                rz_q <= rz_q & ~s2_q[3];
              end else begin
                rbusy_q <= 1'b0;
              end
            end
          end
          if (rdone) begin
            if (cfg_q[`MCS_CFG_INBAND] && rc == spec_q[15:8]) begin
              stop_q <= 1'b1;
            end else if (cfg_q[`MCS_CFG_INBAND] && rc == spec_q[7:0]) begin
              stop_q <= 1'b0;
            end else begin
              rxh_q <= {rc == spec_q[23:16], ~s2_q[3] & rz_q, ~s2_q[3], perr, rc};
              rxh_f_q <= 1'b1;
              if (rxh_f_q && !mv_rx)
                ovr_q <= 1'b1;
            end
          end
          // Modem pins
          if (eos_l[2] && ctx_dat[8:6] == CI)
            chg_q <= 1'b0;
          if (((s2_q[2:0] ^ s3_q[2:0]) & mdm_q[4:2]) != 3'h0)
            chg_q <= 1'b1;
          dtr_q <= cfg_q[`MCS_CFG_DTRFC] ? ({4'h0, rn_q} < thr) : mdm_q[0];
          rts_q <= cfg_q[`MCS_CFG_CTSFC] | mdm_q[1];
        end
      end
    end
  endgenerate

endmodule // mcs_core
`default_nettype wire

/* File: core/mcs_regs.vh */
// Register offsets, field positions, reset values and timing counts of the serial core
`ifndef MCS_REGS_VH
`define MCS_REGS_VH
// ----------------------------------------------------------------
// Address map
// ----------------------------------------------------------------
`define MCS_GLB_BIT      8
`define MCS_CH_STRIDE    32'h0000_0020
`define MCS_OFF_CFG      3'h0
`define MCS_OFF_BAUD     3'h1
`define MCS_OFF_DATA     3'h2
`define MCS_OFF_SPEC     3'h3
`define MCS_OFF_CMD      3'h4
`define MCS_OFF_MDM      3'h5
`define MCS_OFF_STAT     3'h6
`define MCS_OFF_TMR      3'h7
`define MCS_OFF_ACK_RX   3'h0
`define MCS_OFF_ACK_TX   3'h1
`define MCS_OFF_ACK_MDM  3'h2
`define MCS_OFF_EOSR     3'h3
`define MCS_OFF_CTX      3'h4
`define MCS_OFF_GCFG     3'h5
// ----------------------------------------------------------------
// Channel configuration fields
// ----------------------------------------------------------------
`define MCS_CFG_STOP2    2
`define MCS_CFG_PAREN    3
`define MCS_CFG_PARODD   4
`define MCS_CFG_FORCEPE  5
`define MCS_CFG_INBAND   6
`define MCS_CFG_CTSFC    7
`define MCS_CFG_DTRFC    8
`define MCS_CFG_DSRGATE  9
`define MCS_CFG_TXEN     10
`define MCS_CFG_RXEN     11
`define MCS_CFG_TXIE     12
`define MCS_CFG_RST      13'h0C03
`define MCS_BAUD_RST     32'h0000_0000
`define MCS_SPEC_RST     32'h0413_1311
`define MCS_TMR_RST      8'h40
// ----------------------------------------------------------------
// Embedded transmit commands, vectors and timing
// ----------------------------------------------------------------
`define MCS_TXC_BRK_ON   2'h1
`define MCS_TXC_BRK_OFF  2'h2
`define MCS_TXC_DELAY    2'h3
`define MCS_VEC_GOOD     2'h0
`define MCS_VEC_EXC      2'h1
`define MCS_VEC_TX       2'h2
`define MCS_VEC_MDM      2'h3
`define MCS_PRESCALE_MAX 4'hF
`endif

/* File: tb/mcs_core_properties.sv */
// Checker of bus timing and request wires of the serial core
`timescale 1ns/1ps
`default_nettype none
module mcs_core_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [2:0]  srq_n_out,
  input wire logic [2:0]  srq_n_oe_n
);
  logic       dp_q;
  logic       rp_q;
  logic [3:0] ak0_q;
  logic [3:0] ak1_q;
  logic [3:0] ak2_q;
  wire        rd = hsel & hready & htrans[1] & ~hwrite;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_q <= 1'b0;
      rp_q <= 1'b0;
      ak0_q <= 4'h0;
      ak1_q <= 4'h0;
      ak2_q <= 4'h0;
    end else begin
      dp_q <= hsel & hready & htrans[1];
      rp_q <= rd;
      ak0_q <= {ak0_q[2:0], rd & (haddr == 32'h0000_0100)};
      ak1_q <= {ak1_q[2:0], rd & (haddr == 32'h0000_0104)};
      ak2_q <= {ak2_q[2:0], rd & (haddr == 32'h0000_0108)};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_odval; srq_n_out == 3'h0; endproperty
  a_odval: assert property (p_odval) else $error("request wire value not low");
  property p_wait; dp_q |-> !hreadyout; endproperty
  a_wait: assert property (p_wait) else $error("no wait state");
  property p_idle; !dp_q |-> hreadyout; endproperty
  a_idle: assert property (p_idle) else $error("stray wait state");
  property p_hold; $changed(hrdata) |-> $past(rp_q); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rel0; $rose(srq_n_oe_n[0]) |-> (ak0_q != 4'h0); endproperty
  a_rel0: assert property (p_rel0) else $error("rx request dropped");
  property p_rel1; $rose(srq_n_oe_n[1]) |-> (ak1_q != 4'h0); endproperty
  a_rel1: assert property (p_rel1) else $error("tx request dropped");
  property p_rel2; $rose(srq_n_oe_n[2]) |-> (ak2_q != 4'h0); endproperty
  a_rel2: assert property (p_rel2) else $error("modem request dropped");
endmodule // mcs_core_props
bind mcs_core mcs_core_props i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .srq_n_out(srq_n_out), .srq_n_oe_n(srq_n_oe_n));
`default_nettype wire

/* File: tb/mcs_remote.sv */
// Line-side loopback and pulled-up request wires
`timescale 1ns/1ps
`default_nettype none
module mcs_remote (
  input  wire logic [7:0] txd,
  output wire logic [7:0] rxd,
  input  wire logic [2:0] srq_n_out,
  input  wire logic [2:0] srq_n_oe_n,
  output wire logic [2:0] srq_n_in
);
  assign rxd = txd;
  assign srq_n_in = srq_n_out | srq_n_oe_n;
endmodule // mcs_remote
`default_nettype wire

/* File: tb/mcs_core_tb.sv */
// Self-checking testbench of the serial core
`timescale 1ns/1ps
`default_nettype none
module mcs_core_tb;
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize, srq_n_in, srq_n_out, srq_n_oe_n;
  logic [7:0] rxd, txd, cts, dsr, cd, rts, dtr;
  wire [31:0] hrdata;
  wire hreadyout, hresp;
  int n_mismatch, checks;
  mcs_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .txd(txd),
    .cts(cts), .dsr(dsr), .cd(cd), .rts(rts), .dtr(dtr), .srq_n_in(srq_n_in),
    .srq_n_out(srq_n_out), .srq_n_oe_n(srq_n_oe_n));
  mcs_remote i_rem (.txd(txd), .rxd(rxd), .srq_n_out(srq_n_out),
    .srq_n_oe_n(srq_n_oe_n), .srq_n_in(srq_n_in));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    r = hrdata;
    @(posedge hclk);
  endtask
  task wait_rx(input logic [31:0] base);
    bus(base + 32'h18, 1'b0, 32'h0);
    for (int i = 0; i < 60 && r[3:0] == 4'h0; i++) begin
      repeat (20) @(posedge hclk);
      bus(base + 32'h18, 1'b0, 32'h0);
    end
  endtask
  task t_regs;
    bus(32'h0000_0000, 1'b0, 32'h0);
    chk(r, 32'h0000_0C03);
    bus(32'h0000_000C, 1'b0, 32'h0);
    chk(r, 32'h0413_1311);
    bus(32'h0000_001C, 1'b0, 32'h0);
    chk(r, 32'h0000_0040);
    bus(32'h0000_0204, 1'b1, 32'hFFFF_FFFF);
    bus(32'h0000_0204, 1'b0, 32'h0);
    chk(r, 32'h0);
    bus(32'h0000_0044, 1'b1, 32'h0003_0002);
    bus(32'h0000_0044, 1'b0, 32'h0);
    chk(r, 32'h0003_0002);
    bus(32'h0000_0064, 1'b0, 32'h0);
    chk(r, 32'h0);
  endtask
  task t_modem;
    cts <= 8'h01;
    dsr <= 8'h01;
    cd <= 8'h01;
    bus(32'h0000_0014, 1'b1, 32'h3);
    repeat (4) @(posedge hclk);
    chk({dtr[0], rts[0]}, 2'h3);
    bus(32'h0000_0014, 1'b0, 32'h0);
    chk(r & 32'h1C3, 32'h1C3);
    bus(32'h0000_0014, 1'b1, 32'h4);
    cts <= 8'h00;
    repeat (10) @(posedge hclk);
    chk(srq_n_oe_n[2], 1'b0);
    bus(32'h0000_0108, 1'b0, 32'h0);
    chk(r, 32'h98);
    bus(32'h0000_010C, 1'b1, 32'h2);
    bus(32'h0000_0014, 1'b0, 32'h0);
    chk(r & 32'h3FF, 32'h184);
    bus(32'h0000_0014, 1'b1, 32'h0);
  endtask
  task t_loop;
    bus(32'h0000_0008, 1'b1, 32'h55);
    wait_rx(32'h0);
    bus(32'h0000_0008, 1'b0, 32'h0);
    chk(r & 32'hFFF, 32'h55);
    bus(32'h0000_0010, 1'b1, 32'h1);
    wait_rx(32'h0);
    bus(32'h0000_0008, 1'b0, 32'h0);
    chk(r & 32'hFFF, 32'h11);
    bus(32'h0000_0008, 1'b1, 32'h13);
    wait_rx(32'h0);
    bus(32'h0000_0008, 1'b0, 32'h0);
    chk(r & 32'hFFF, 32'h813);
  endtask
  task t_cts;
    cts <= 8'h00;
    bus(32'h0000_0020, 1'b1, 32'h0C83);
    bus(32'h0000_0028, 1'b1, 32'hA5);
    repeat (400) @(posedge hclk);
    chk(rts[1], 1'b1);
    bus(32'h0000_0038, 1'b0, 32'h0);
    chk(r[3:0], 4'h0);
    cts <= 8'h02;
    wait_rx(32'h20);
    bus(32'h0000_0028, 1'b0, 32'h0);
    chk(r & 32'hFFF, 32'hA5);
  endtask
  task t_txreq;
    bus(32'h0000_0114, 1'b1, 32'h1);
    bus(32'h0000_0114, 1'b0, 32'h0);
    chk(r, 32'h1);
    bus(32'h0000_0000, 1'b1, 32'h1C03);
    for (int i = 0; i < 500 && srq_n_in[1] !== 1'b0; i++) @(posedge hclk);
    chk(srq_n_oe_n[1], 1'b0);
    bus(32'h0000_0104, 1'b0, 32'h0);
    chk(r, 32'h90);
    repeat (3) @(posedge hclk);
    chk(srq_n_oe_n[1], 1'b1);
    bus(32'h0000_0000, 1'b1, 32'h0C03);
    bus(32'h0000_010C, 1'b1, 32'h1);
    bus(32'h0000_0104, 1'b0, 32'h0);
    chk(r, 32'h0);
  endtask
  task results;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cts = 8'h00;
    dsr = 8'h00;
    cd = 8'h00;
    n_mismatch = 0;
    checks = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_modem;
    t_loop;
    t_cts;
    t_txreq;
    results;
  end
  initial begin
    repeat (30000) @(posedge hclk);
    n_mismatch++;
    results;
  end
endmodule // mcs_core_tb
`default_nettype wire
